// ---- test_write_once_device_config_store.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Self-checking bench for the write-once configuration store
// ----------------------------------------------------------------
module test_write_once_device_config_store;
    logic clock;
    logic rst_b;
    logic [23:0] address;
    logic table_read;
    logic table_write;
    logic [7:0] write_data;
    logic [7:0] read_data;
    logic read_valid;
    logic [7:0] config_word [12];
    logic boot_write_allowed;
    logic boot_write_request;
    logic boot_write_grant;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;

    // Core clock and hang guard
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            give_verdict();
        end
    end

    wocfg_core_model u_wocfg_core_model (.clock(clock), .address(address),
        .table_read(table_read), .table_write(table_write),
        .write_data(write_data));
    wocfg_store u_wocfg_store (.clock(clock), .rst_b(rst_b),
        .address(address), .table_read(table_read),
        .table_write(table_write), .write_data(write_data),
        .read_data(read_data), .read_valid(read_valid),
        .config_word(config_word),
        .boot_write_allowed(boot_write_allowed),
        .boot_write_request(boot_write_request),
        .boot_write_grant(boot_write_grant));

    // Compare and count
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Power-on reset held for 16 cycles
    task automatic power_cycle();
        @(negedge clock);
        rst_b = 1'b0;
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
    endtask

    // Read one mapped word and compare every view of it
    task automatic read_word(int i, logic [7:0] exp);
        u_wocfg_core_model.cfg_read(wocfg_pkg::cfg_map_base + 24'(2 * i));
        check("read_valid", {7'h00, read_valid}, 8'h01);
        check("read_data", read_data, exp);
        check("config_word", config_word[i], exp);
    endtask

    // Erased map: implemented bits 1, others 0
    task automatic test_erased();
        for (int i = 0; i < 12; i++) begin
            read_word(i, wocfg_pkg::impl_mask[i]);
        end
    endtask

    // Boot segment write grant follows the protect bit
    task automatic test_boot(logic exp);
        @(negedge clock);
        check("idle grant", {7'h00, boot_write_grant}, 8'h00);
        boot_write_request = 1'b1;
        @(negedge clock);
        check("boot allowed", {7'h00, boot_write_allowed}, 8'(exp));
        check("boot grant", {7'h00, boot_write_grant}, 8'(exp));
        boot_write_request = 1'b0;
    endtask

    // Program each word, then try to erase it by writing ones
    task automatic test_program();
        logic [7:0] erased_view; // Erased view of the following word
        for (int i = 0; i < 12; i++) begin
            u_wocfg_core_model.cfg_write(24'hf80000 + 24'(2 * i), 8'ha4);
            read_word(i, 8'ha4 & wocfg_pkg::impl_mask[i]);
            if (i < 11) begin
                erased_view = wocfg_pkg::impl_mask[i + 1];
                check("next word", config_word[i + 1], erased_view);
            end
            u_wocfg_core_model.cfg_write(24'hf80000 + 24'(2 * i), 8'hff);
            read_word(i, 8'ha4 & wocfg_pkg::impl_mask[i]);
        end
    endtask

    // Reads outside the map and outside configuration space
    task automatic test_space();
        u_wocfg_core_model.cfg_read(24'h7ffffe);
        check("low read_valid", {7'h00, read_valid}, 8'h00);
        check("low read_data", read_data, wocfg_pkg::impl_mask[11]);
        u_wocfg_core_model.cfg_read(24'hf80001);
        check("odd read_data", read_data, 8'h00);
        u_wocfg_core_model.cfg_read(24'hf80018);
        check("past map read_data", read_data, 8'h00);
        // Writes below the space or at an odd address program nothing
        u_wocfg_core_model.cfg_write(24'h780000, 8'h00);
        u_wocfg_core_model.cfg_write(24'hf80001, 8'h00);
        read_word(0, wocfg_pkg::impl_mask[0]);
    endtask

    // Main sequence
    initial begin
        rst_b = 1'b0;
        boot_write_request = 1'b0;
        power_cycle();
        test_erased();
        test_boot(1'b1);
        test_space();
        test_program();
        test_boot(1'b0);
        power_cycle();
        test_erased();
        give_verdict();
    end
endmodule

// ---- wocfg_cell.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// One write-once configuration byte
// ----------------------------------------------------------------
module wocfg_cell (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic write_strobe,
    input wire logic [7:0] write_data,
    input wire logic [7:0] implemented,
    output logic [7:0] stored
);

    // Cells erase only at power-on; a programmed bit can only go to 0
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stored <= wocfg_pkg::erased_value;
        end else if (write_strobe) begin
            // A 0 programs an implemented bit, a 1 leaves the cell; programmed cells stay
            stored <= stored & (write_data | ~implemented); // RQ4 RQ8
        end
    end

endmodule

// ---- wocfg_core_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Processor core model issuing table reads and table writes
// ----------------------------------------------------------------
module wocfg_core_model (
    input wire logic clock,
    output logic [23:0] address,
    output logic table_read,
    output logic table_write,
    output logic [7:0] write_data
);
    // Idle bus before the first access
    initial begin
        address = 24'h000000;
        table_read = 1'b0;
        table_write = 1'b0;
        write_data = 8'h00;
    end

    // One table write, taken at the next rising edge
    task automatic cfg_write(input logic [23:0] a, input logic [7:0] d);
        @(negedge clock);
        address = a;
        write_data = d;
        table_write = 1'b1;
        @(negedge clock);
        table_write = 1'b0;
        address = ~a;
        write_data = ~d;
    endtask

    // One table read; the answer stands when this task returns
    task automatic cfg_read(input logic [23:0] a);
        @(negedge clock);
        address = a;
        table_read = 1'b1;
        @(negedge clock);
        table_read = 1'b0;
        address = ~a;
    endtask
endmodule

// ---- wocfg_pkg.sv ----
package wocfg_pkg;

    // ------------------------------------------------------------
    // Address space and map
    // ------------------------------------------------------------
    localparam int addr_width = 24;
    localparam int word_count = 12;
    localparam logic [23:0] cfg_space_base = 24'h800000;
    localparam logic [23:0] cfg_map_base = 24'hf80000;
    localparam logic [23:0] cfg_map_last = 24'hf80016;
    localparam int index_lsb = 1;

    // ------------------------------------------------------------
    // Word offsets (byte addresses in configuration space)
    // ------------------------------------------------------------
    localparam logic [23:0] boot_segment_protection_config = 24'hf80000;
    localparam logic [23:0] secure_segment_protection_config = 24'hf80002;
    localparam logic [23:0] general_segment_protection_config = 24'hf80004;
    localparam logic [23:0] initial_oscillator_select_config = 24'hf80006;
    localparam logic [23:0] oscillator_options_config = 24'hf80008;
    localparam logic [23:0] watchdog_options_config = 24'hf8000a;
    localparam logic [23:0] power_on_options_config = 24'hf8000c;
    localparam logic [23:0] debug_channel_config = 24'hf8000e;
    localparam logic [23:0] user_unit_id_byte_0 = 24'hf80010;
    localparam logic [23:0] user_unit_id_byte_1 = 24'hf80012;
    localparam logic [23:0] user_unit_id_byte_2 = 24'hf80014;
    localparam logic [23:0] user_unit_id_byte_3 = 24'hf80016;

    // ------------------------------------------------------------
    // Implemented-bit masks per word, index 0 first
    // ------------------------------------------------------------
    localparam logic [7:0] impl_mask [word_count] = '{
        8'hcf, 8'hcf, 8'h07, 8'h87, 8'he7, 8'hdf,
        8'hff, 8'he3, 8'hff, 8'hff, 8'hff, 8'hff
    };

    // ------------------------------------------------------------
    // Unprogrammed cell value and boot write-protect position
    // ------------------------------------------------------------
    localparam logic [7:0] erased_value = 8'hff;
    localparam int boot_write_protect_bit = 0;
    localparam int boot_word_index = 0;

endpackage

// ---- wocfg_store.sv ----
`timescale 1ns/1ns
// Overview of operation
// RQ1 - Programmed bits read 0, unprogrammed read 1
// RQ2 - Words from 0xf80000 in two-address steps
// RQ3 - Map reached only by table read and write
// RQ4 - Each bit programs once per power cycle
// RQ5 - Core cycles power to change configuration
// RQ6 - Unimplemented bit positions always read 0
// RQ7 - Boot writes allowed only while protect bit 1
// RQ8 - Writes to programmed bits change nothing
module wocfg_store (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [23:0] address,
    input wire logic table_read,
    input wire logic table_write,
    input wire logic [7:0] write_data,
    output logic [7:0] read_data,
    output logic read_valid,
    output logic [7:0] config_word [12],
    output logic boot_write_allowed,
    input wire logic boot_write_request,
    output logic boot_write_grant
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic in_space; // Address inside configuration space
    logic in_map; // Address hits a word of the map
    logic [3:0] word_index; // Selected word
    logic [7:0] cell_value [12]; // Raw cell contents
    logic [7:0] next_read_data; // Read value before the register

    // Decode runs every cycle; table_read and table_write gate its use below
    always_comb begin
        in_space = address >= wocfg_pkg::cfg_space_base; // RQ3
        in_map = in_space && !address[0] &&
            address >= wocfg_pkg::cfg_map_base &&
            address <= wocfg_pkg::cfg_map_last; // RQ2
        word_index = 4'(address[4:1]);
    end

    // ------------------------------------------------------------
    // Cell bank
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < wocfg_pkg::word_count; gi++) begin : g_cell
            logic hit; // Write strobe for this word
            assign hit = table_write && in_map &&
                word_index == 4'(gi); // RQ3
            wocfg_cell u_cell (
                .clock(clock),
                .rst_b(rst_b),
                .write_strobe(hit),
                .write_data(write_data),
                .implemented(wocfg_pkg::impl_mask[gi]),
                .stored(cell_value[gi])
            );
            // Unimplemented positions are forced to 0
            assign config_word[gi] =
                cell_value[gi] & wocfg_pkg::impl_mask[gi]; // RQ6 RQ1
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unmapped configuration addresses read as erased-free zero
    always_comb begin
        next_read_data = 8'h00;
        if (in_map) begin
            next_read_data = config_word[word_index]; // RQ1 RQ6
        end
    end

    // Read data registered one cycle after the table read
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            read_data <= 8'h00;
            read_valid <= 1'b0;
        end else begin
            read_valid <= table_read && in_space; // RQ3
            if (table_read && in_space) begin
                read_data <= next_read_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Boot segment write gate
    // ------------------------------------------------------------
    // Boot writes pass only while the protect bit is still 1
    always_comb begin
        boot_write_allowed = config_word[wocfg_pkg::boot_word_index]
            [wocfg_pkg::boot_write_protect_bit]; // RQ7
        boot_write_grant = boot_write_request && boot_write_allowed; // RQ7
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_write_zero_bit0;
        table_write && in_map && !write_data[0];
    endsequence

    property p_read_map;
        @(posedge clock) disable iff (!rst_b)
        (table_read && in_map) |=>
            read_valid && read_data == $past(config_word[word_index]);
    endproperty
    a_read_map: assert property (p_read_map) // RQ1
        else $error("Read data mismatch");

    property p_plain_ignored;
        @(posedge clock) disable iff (!rst_b)
        (!table_read) |=> !read_valid;
    endproperty
    a_plain_ignored: assert property (p_plain_ignored) // RQ3
        else $error("Read answered without table read");

    property p_no_set;
        @(posedge clock) disable iff (!rst_b)
        ##1 (($past(config_word[0]) | config_word[0]) ==
            $past(config_word[0]));
    endproperty
    a_no_set: assert property (p_no_set) // RQ4
        else $error("Programmed bit returned to 1");

    property p_program;
        @(posedge clock) disable iff (!rst_b)
        (s_write_zero_bit0 and word_index == 4'h0) |=>
            !config_word[0][0];
    endproperty
    a_program: assert property (p_program) // RQ4
        else $error("Write did not program bit");

    property p_unimpl;
        @(posedge clock) disable iff (!rst_b)
        (config_word[2] & ~wocfg_pkg::impl_mask[2]) == 8'h00;
    endproperty
    a_unimpl: assert property (p_unimpl) // RQ6
        else $error("Unimplemented bit read 1");

    property p_boot_gate;
        @(posedge clock) disable iff (!rst_b)
        boot_write_grant |-> config_word[0][0];
    endproperty
    a_boot_gate: assert property (p_boot_gate) // RQ7
        else $error("Boot write granted while protected");

    property p_boot_open;
        @(posedge clock) disable iff (!rst_b)
        (boot_write_request && config_word[0][0]) |-> boot_write_grant;
    endproperty
    a_boot_open: assert property (p_boot_open) // RQ7
        else $error("Boot write refused while open");

    property p_reprogram_noop;
        @(posedge clock) disable iff (!rst_b)
        (!config_word[1][0] && table_write) |=> !config_word[1][0];
    endproperty
    a_reprogram_noop: assert property (p_reprogram_noop) // RQ8
        else $error("Programmed bit changed");

    // ------------------------------------------------------------
    // Checks: read answers
    // ------------------------------------------------------------
    // A table read inside configuration space
    sequence s_read_in_space;
        table_read && in_space;
    endsequence

    // A table read below configuration space
    sequence s_read_below_space;
        table_read && !in_space;
    endsequence

    // A table read of an odd or unmapped configuration address
    sequence s_read_unmapped;
        table_read && in_space && !in_map;
    endsequence

    // Every configuration-space read is answered next cycle
    property p_read_space;
        @(posedge clock) disable iff (!rst_b)
        s_read_in_space |=> read_valid;
    endproperty
    a_read_space: assert property (p_read_space) // RQ3
        else $error("Configuration read not answered");

    // Reads below the space are never answered
    property p_read_below;
        @(posedge clock) disable iff (!rst_b)
        s_read_below_space |=> !read_valid;
    endproperty
    a_read_below: assert property (p_read_below) // RQ3
        else $error("Read below configuration space answered");

    // Unmapped configuration addresses answer with zero
    property p_read_unmapped;
        @(posedge clock) disable iff (!rst_b)
        s_read_unmapped |=> read_valid && read_data == 8'h00;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) // RQ2
        else $error("Unmapped read returned data");

    // Read data stands until the next configuration-space read
    property p_read_hold;
        @(posedge clock) disable iff (!rst_b)
        !(table_read && in_space) |=> $stable(read_data);
    endproperty
    a_read_hold: assert property (p_read_hold) // RQ3
        else $error("Read data changed without a read");

    // A mapped address always selects one of the words
    property p_index_range;
        @(posedge clock) disable iff (!rst_b)
        in_map |-> in_space && word_index < 4'(wocfg_pkg::word_count);
    endproperty
    a_index_range: assert property (p_index_range) // RQ2
        else $error("Mapped address outside the word range");

    // ------------------------------------------------------------
    // Checks: per-word cell behaviour
    // ------------------------------------------------------------
    genvar ci;
    generate
        for (ci = 0; ci < wocfg_pkg::word_count; ci++) begin : g_check
            // A table write that lands on this word
            sequence s_word_write;
                table_write && in_map && word_index == 4'(ci);
            endsequence

            // Other cycles leave the cells of this word alone
            property p_word_keep;
                @(posedge clock) disable iff (!rst_b)
                !(table_write && in_map && word_index == 4'(ci)) |=>
                    $stable(cell_value[ci]);
            endproperty
            a_word_keep: assert property (p_word_keep) // RQ3
                else $error("Cell changed without a table write");

            // No cell bit ever goes back from 0 to 1
            property p_word_no_set;
                @(posedge clock) disable iff (!rst_b)
                ##1 (($past(cell_value[ci]) | cell_value[ci]) ==
                    $past(cell_value[ci]));
            endproperty
            a_word_no_set: assert property (p_word_no_set) // RQ4 RQ8
                else $error("Programmed cell bit returned to 1");

            // Written zeros program every implemented bit
            property p_word_program;
                @(posedge clock) disable iff (!rst_b)
                s_word_write |=> (cell_value[ci] & ~$past(write_data) &
                    wocfg_pkg::impl_mask[ci]) == 8'h00;
            endproperty
            a_word_program: assert property (p_word_program) // RQ4
                else $error("Written zero did not program");

            // Reads of this word show no unimplemented bit
            property p_word_read;
                @(posedge clock) disable iff (!rst_b)
                (table_read && in_map && word_index == 4'(ci)) |=>
                    (read_data & ~wocfg_pkg::impl_mask[ci]) == 8'h00;
            endproperty
            a_word_read: assert property (p_word_read) // RQ6
                else $error("Unimplemented bit read as 1");
        end
    endgenerate

    // ------------------------------------------------------------
    // Checks: boot gate and power-on state
    // ------------------------------------------------------------
    // Power-on reset held across two edges
    sequence s_held_reset;
        !rst_b ##1 !rst_b;
    endsequence

    // Once the protect bit is programmed the gate stays shut
    property p_boot_stays_shut;
        @(posedge clock) disable iff (!rst_b)
        !boot_write_allowed |=> !boot_write_allowed;
    endproperty
    a_boot_stays_shut: assert property (p_boot_stays_shut) // RQ7
        else $error("Boot gate reopened without power cycle");

    // No grant without a request
    property p_boot_idle;
        @(posedge clock) disable iff (!rst_b)
        !boot_write_request |-> !boot_write_grant;
    endproperty
    a_boot_idle: assert property (p_boot_idle) // RQ7
        else $error("Boot write granted without request");

    // Power-on reset leaves word 0 erased, the boot gate open and the read port quiet
    property p_power_on;
        @(posedge clock)
        s_held_reset |-> !read_valid && read_data == 8'h00 &&
            config_word[0] == wocfg_pkg::impl_mask[0] &&
            boot_write_allowed;
    endproperty
    a_power_on: assert property (p_power_on) // RQ4
        else $error("Power-on state not erased");

endmodule
